// File: lai_map.svh
// constants for the limit alert interrupt logic
// assumes inclusion by lai_pkg users and the top module
`ifndef LAI_MAP_SVH
`define LAI_MAP_SVH
`define LAI_ARA_ADDR 7'h0c
`define LAI_NUM_SRC 7
`define LAI_STAT1_INT_TEMP 0
`define LAI_STAT1_EXT_TEMP 1
`define LAI_STAT1_SUPPLY 2
`define LAI_STAT2_AIN_LSB 0
`define LAI_STAT_RESET 8'h00
`define LAI_POL_RESET 1'b0
`define LAI_DIS_RESET 1'b0
`endif

// File: lai_pkg.sv
// types for the limit alert interrupt logic
// assumes lai_map.svh constants
package lai_pkg;
    typedef struct packed {
        logic scl;
        logic sda;
    } lai_bus_in_t;
    typedef struct packed {
        logic sda_oe_n;
        logic alert_oe_n;
    } lai_bus_out_t;
    typedef enum logic [2:0] {
        LAI_IDLE,
        LAI_ADDR,
        LAI_ACK,
        LAI_SEND,
        LAI_RACK,
        LAI_WAIT
    } lai_state_t;
endpackage

// File: lai_ara_responder.sv
// alert response address responder on the two-wire bus
// assumes scl and sda already synchronised to clk_i
`include "lai_map.svh"
module lai_ara_responder (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic alerting_i,
    input wire logic [6:0] dev_addr_i,
    output logic sda_oe_n_o,
    output logic answered_o
);
    lai_pkg::lai_state_t state_q;
    logic scl_q;
    logic sda_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic [7:0] tx_q;
    logic lost_q;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    assign scl_rise = scl_i & ~scl_q;
    assign scl_fall = ~scl_i & scl_q;
    assign start_c = scl_i & scl_q & sda_q & ~sda_i;
    assign stop_c = scl_i & scl_q & ~sda_q & sda_i;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else if (en_i)
        begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= lai_pkg::LAI_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            tx_q <= 8'hff;
            lost_q <= 1'b0;
            sda_oe_n_o <= 1'b1;
            answered_o <= 1'b0;
        end
        else if (en_i)
        begin
            answered_o <= 1'b0;
            if (start_c)
            begin
                state_q <= lai_pkg::LAI_ADDR;
                bit_q <= 4'h0;
                sda_oe_n_o <= 1'b1;
            end
            else if (stop_c)
            begin
                state_q <= lai_pkg::LAI_IDLE;
                sda_oe_n_o <= 1'b1;
            end
            else
            begin
                unique case (state_q)
                    lai_pkg::LAI_IDLE, lai_pkg::LAI_WAIT:
                    begin
                        sda_oe_n_o <= 1'b1;
                    end
                    lai_pkg::LAI_ADDR:
                    begin
                        if (scl_rise)
                        begin
                            sh_q <= {sh_q[6:0], sda_i};
                            bit_q <= bit_q + 4'h1;
                        end
                        else if (scl_fall && bit_q == 4'h8)
                        begin
                            // address read matches alert response address
                            if (sh_q == {`LAI_ARA_ADDR, 1'b1} && alerting_i)
                            begin
                                sda_oe_n_o <= 1'b0;
                                state_q <= lai_pkg::LAI_ACK;
                            end
                            else
                                state_q <= lai_pkg::LAI_WAIT;
                        end
                    end
                    lai_pkg::LAI_ACK:
                    begin
                        if (scl_fall)
                        begin
                            tx_q <= {dev_addr_i, 1'b1};
                            sda_oe_n_o <= dev_addr_i[6];
                            bit_q <= 4'h1;
                            lost_q <= 1'b0;
                            state_q <= lai_pkg::LAI_SEND;
                        end
                    end
                    lai_pkg::LAI_SEND:
                    begin
                        if (scl_rise && sda_oe_n_o && !sda_i)
                        begin
                            lost_q <= 1'b1;
                        end
                        else if (scl_fall)
                        begin
                            if (lost_q)
                            begin
                                sda_oe_n_o <= 1'b1;
                                state_q <= lai_pkg::LAI_WAIT;
                            end
                            else if (bit_q == 4'h8)
                            begin
                                sda_oe_n_o <= 1'b1;
                                answered_o <= 1'b1;
                                state_q <= lai_pkg::LAI_RACK;
                            end
                            else
                            begin
                                sda_oe_n_o <= tx_q[3'(7 - bit_q)];
                                bit_q <= bit_q + 4'h1;
                            end
                        end
                    end
                    lai_pkg::LAI_RACK:
                    begin
                        if (scl_fall)
                            state_q <= lai_pkg::LAI_WAIT;
                    end
                    default:
                    begin
                        state_q <= lai_pkg::LAI_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

// File: lai_alert_top.sv
// out-of-limit status flags, alert output and alert response
// assumes conversion results arrive with a one-cycle valid strobe on clk_i
`include "lai_map.svh"
module lai_alert_top #(
    parameter int unsigned DATA_W = 10,
    parameter int unsigned AIN_N = 4
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic [6:0] dev_addr_i,
    input wire logic two_wire_sel_i,
    input wire logic alert_polarity_select_i,
    input wire logic alert_disable_i,
    input wire logic [AIN_N+2:0] conv_valid_i,
    input wire logic [(AIN_N+3)*DATA_W-1:0] conv_data_i,
    input wire logic [(AIN_N+3)*DATA_W-1:0] limit_high_i,
    input wire logic [(AIN_N+3)*DATA_W-1:0] limit_low_i,
    input wire logic stat1_rd_i,
    input wire logic stat2_rd_i,
    input wire lai_pkg::lai_bus_in_t bus_i,
    output logic [7:0] stat1_o,
    output logic [7:0] stat2_o,
    output logic alert_o,
    output logic alert_oe_n_o,
    output logic sda_o,
    output logic sda_oe_n_o,
    output logic answered_o
);
    localparam int unsigned NS = AIN_N + 3;

    // status register 2 holds at most eight channel flags
    if (AIN_N < 1 || AIN_N > 8)
    begin : g_bad_ain
        $error("analog input count must be 1 to 8");
    end
    if (DATA_W < 1)
    begin : g_bad_width
        $error("data width must be at least 1");
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic scl_q;
    logic sda_q;
    // clock line: idle high, change taken once stages two and three agree
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            scl_s <= 3'h7;
            scl_q <= 1'b1;
        end
        else if (clk_en_i)
        begin
            scl_s <= {scl_s[1:0], bus_i.scl};
            if (scl_s[1] == scl_s[2])
                scl_q <= scl_s[2];
        end
    end

    // data line: same filter, so both lines keep the same latency
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sda_s <= 3'h7;
            sda_q <= 1'b1;
        end
        else if (clk_en_i)
        begin
            sda_s <= {sda_s[1:0], bus_i.sda};
            if (sda_s[1] == sda_s[2])
                sda_q <= sda_s[2];
        end
    end

    // ------------------------------------------------------------
    // limit compare and status flags
    // ------------------------------------------------------------
    function automatic logic out_of_limit(input logic [DATA_W-1:0] v, input logic [DATA_W-1:0] hi,
                                          input logic [DATA_W-1:0] lo);
        out_of_limit = (v > hi) || (v < lo);
    endfunction

    logic [NS-1:0] flag_q;
    logic [NS-1:0] oor_q;
    logic [NS-1:0] read_q;
    logic [NS-1:0] hit_c;
    logic [NS-1:0] ok_c;
    logic [NS-1:0] rd_c;
    always_comb
    begin
        for (int i = 0; i < NS; i++)
        begin
            hit_c[i] = conv_valid_i[i] &&
                out_of_limit(conv_data_i[i*DATA_W +: DATA_W], limit_high_i[i*DATA_W +: DATA_W],
                             limit_low_i[i*DATA_W +: DATA_W]);
            ok_c[i] = conv_valid_i[i] && !hit_c[i];
            rd_c[i] = (i < 3) ? stat1_rd_i : stat2_rd_i;
        end
    end

    // ------------------------------------------------------------
    // out-of-range tracking
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            oor_q <= '0;
        end
        else if (clk_en_i)
        begin
            for (int i = 0; i < NS; i++)
            begin
                if (hit_c[i])
                    oor_q[i] <= 1'b1;
                else if (ok_c[i])
                    oor_q[i] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // status read tracking
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            read_q <= '0;
        end
        else if (clk_en_i)
        begin
            for (int i = 0; i < NS; i++)
            begin
                // a read before the violation does not count
                if (hit_c[i])
                    read_q[i] <= 1'b0;
                else if (rd_c[i] && flag_q[i])
                    read_q[i] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // latched flags
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            flag_q <= '0;
        end
        else if (clk_en_i)
        begin
            for (int i = 0; i < NS; i++)
            begin
                // a hit in the same cycle beats a clear
                if (hit_c[i])
                    flag_q[i] <= 1'b1;
                else if ((ok_c[i] || !oor_q[i]) && (read_q[i] || rd_c[i]))
                    flag_q[i] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // status registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            stat1_o <= `LAI_STAT_RESET;
            stat2_o <= `LAI_STAT_RESET;
        end
        else if (clk_en_i)
        begin
            stat1_o <= `LAI_STAT_RESET;
            stat2_o <= `LAI_STAT_RESET;
            stat1_o[`LAI_STAT1_INT_TEMP] <= flag_q[0];
            stat1_o[`LAI_STAT1_EXT_TEMP] <= flag_q[1];
            stat1_o[`LAI_STAT1_SUPPLY] <= flag_q[2];
            stat2_o[`LAI_STAT2_AIN_LSB +: AIN_N] <= flag_q[NS-1:3];
        end
    end

    // ------------------------------------------------------------
    // alert pin
    // ------------------------------------------------------------
    logic active_c;
    assign active_c = (|flag_q) && !alert_disable_i;
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            alert_o <= 1'b1;
            alert_oe_n_o <= 1'b1;
        end
        else if (clk_en_i)
        begin
            if (two_wire_sel_i)
            begin
                alert_o <= 1'b0;
                alert_oe_n_o <= !active_c;
            end
            else
            begin
                alert_oe_n_o <= 1'b0;
                alert_o <= alert_polarity_select_i ? active_c : !active_c;
            end
        end
    end

    // ------------------------------------------------------------
    // alert response
    // ------------------------------------------------------------
    logic ara_oe_n;
    assign sda_o = 1'b0;
    // responder freezes outside two-wire mode, so never leave the line held low
    assign sda_oe_n_o = ara_oe_n || !two_wire_sel_i;
    lai_ara_responder u_ara (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .en_i(clk_en_i & two_wire_sel_i),
        .scl_i(scl_q),
        .sda_i(sda_q),
        .alerting_i(active_c),
        .dev_addr_i(dev_addr_i),
        .sda_oe_n_o(ara_oe_n),
        .answered_o(answered_o)
    );
endmodule

// File: lai_alert_top_properties.sv
// assertions on the limit alert interrupt ports
// assumes bind into lai_alert_top, one clock domain
module lai_alert_top_properties #(
    parameter int unsigned DATA_W = 10,
    parameter int unsigned AIN_N = 4
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic two_wire_sel_i,
    input wire logic alert_polarity_select_i,
    input wire logic alert_disable_i,
    input wire logic [AIN_N+2:0] conv_valid_i,
    input wire logic [(AIN_N+3)*DATA_W-1:0] conv_data_i,
    input wire logic [(AIN_N+3)*DATA_W-1:0] limit_high_i,
    input wire logic [(AIN_N+3)*DATA_W-1:0] limit_low_i,
    input wire logic stat1_rd_i,
    input wire logic [7:0] stat1_o,
    input wire logic [7:0] stat2_o,
    input wire logic alert_o,
    input wire logic alert_oe_n_o,
    input wire logic sda_o,
    input wire logic sda_oe_n_o,
    input wire logic answered_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    logic flag;
    logic tw;
    logic pol;
    logic dis;
    assign flag = (|stat1_o) || (|stat2_o);
    assign tw = two_wire_sel_i;
    assign pol = alert_polarity_select_i;
    assign dis = alert_disable_i;
    AST_HIGH_TRIP: assert property (
        clk_en_i && conv_valid_i[0] && conv_data_i[DATA_W-1:0] > limit_high_i[DATA_W-1:0] ##1 clk_en_i
        |=> stat1_o[0]) else $error("high trip not flagged");
    AST_LOW_TRIP: assert property (
        clk_en_i && conv_valid_i[3] && conv_data_i[3*DATA_W+:DATA_W] < limit_low_i[3*DATA_W+:DATA_W]
        ##1 clk_en_i |=> stat2_o[0]) else $error("low trip not flagged");
    AST_FLAG_HOLD: assert property (
        stat1_o[0] && !$past(stat1_rd_i) && !$past(conv_valid_i[0]) |=> stat1_o[0])
        else $error("status flag dropped without cause");
    AST_OD_DRIVE: assert property (
        tw && $past(tw) |-> alert_oe_n_o || !alert_o) else $error("alert driven high in two-wire mode");
    AST_OD_FOLLOW: assert property (
        tw && $past(tw) && !dis && !$past(dis) |-> alert_oe_n_o == !flag) else $error("alert not tracking status");
    AST_POLARITY: assert property (
        !tw && !$past(tw) && !dis && !$past(dis) && $stable(pol) && $past(rst_n_i)
        |-> !alert_oe_n_o && alert_o == (flag ? pol : !pol)) else $error("push-pull level wrong");
    AST_DISABLE: assert property (
        dis && $past(dis) && $stable(tw) && $stable(pol) |-> alert_oe_n_o || alert_o != (tw ? 1'b0 : pol))
        else $error("disabled alert still active");
    AST_SDA_OD: assert property (
        !sda_oe_n_o |-> !sda_o && tw) else $error("data line driven outside two-wire mode");
    AST_ANSWER_PULSE: assert property (
        answered_o |-> tw ##1 !answered_o) else $error("answer pulse wrong");
    cover property (answered_o);
    cover property ($fell(stat2_o[0]));
    cover property (!alert_oe_n_o && alert_o);
endmodule
bind lai_alert_top lai_alert_top_properties #(.DATA_W(DATA_W), .AIN_N(AIN_N)) i_props (.clk_i, .rst_n_i,
    .clk_en_i, .two_wire_sel_i, .alert_polarity_select_i, .alert_disable_i, .conv_valid_i, .conv_data_i,
    .limit_high_i, .limit_low_i, .stat1_rd_i, .stat1_o, .stat2_o, .alert_o, .alert_oe_n_o, .sda_o,
    .sda_oe_n_o, .answered_o);

// File: lai_smb_host.sv
// two-wire host that reads the alert response address
// assumes pulled-up alert and data lines resolved outside
module lai_smb_host (
    input wire logic alert_line_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o,
    output logic [7:0] rx_o,
    output int n_ara_o
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic bit_out(input logic b);
        sda_low_o = !b;
        #16 scl_o = 1'b1;
        #32 scl_o = 1'b0;
        #16;
    endtask
    task automatic bit_in(output logic b);
        sda_low_o = 1'b0;
        #16 scl_o = 1'b1;
        #16 b = sda_i;
        #16 scl_o = 1'b0;
        #16;
    endtask
    initial
    begin
        logic ack;
        logic [7:0] sh;
        scl_o = 1'b1;
        sda_low_o = 1'b0;
        rx_o = 8'h00;
        n_ara_o = 0;
        forever
        begin
            wait (alert_line_i === 1'b0);
            #200 sda_low_o = 1'b1;
            #16 scl_o = 1'b0;
            #16;
            for (int i = 7; i >= 0; i--)
                bit_out(8'h19 >> i);
            bit_in(ack);
            for (int i = 7; i >= 0; i--)
                bit_in(sh[i]);
            bit_out(1'b1);
            sda_low_o = 1'b1;
            #16 scl_o = 1'b1;
            #16 sda_low_o = 1'b0;
            rx_o = ack ? 8'hff : sh;
            n_ara_o++;
            #500;
        end
    end
endmodule

// File: tb_lai_alert_top.sv
// testbench for the limit alert interrupt logic
// assumes lai_smb_host on the wired alert and data lines
module tb_lai_alert_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic [6:0] dev_addr_i = 7'h2a;
    logic two_wire_sel_i = 1'b1;
    logic alert_polarity_select_i = 1'b0;
    logic alert_disable_i = 1'b0;
    logic [6:0] conv_valid_i = 7'h00;
    logic [69:0] conv_data_i = {7{10'h100}};
    logic [69:0] limit_high_i = {7{10'h200}};
    logic [69:0] limit_low_i = {7{10'h040}};
    logic stat1_rd_i = 1'b0;
    logic stat2_rd_i = 1'b0;
    logic [7:0] stat1_o;
    logic [7:0] stat2_o;
    logic [7:0] rx;
    logic alert_o, alert_oe_n_o, sda_o, sda_oe_n_o, answered_o, scl, host_low;
    int n_ara;
    int n_fail = 0;
    int n_checks = 0;
    wire line = (!alert_oe_n_o && !alert_o) ? 1'b0 : 1'b1;
    wire sda_line = !(host_low || !sda_oe_n_o);
    lai_pkg::lai_bus_in_t bus_i;
    assign bus_i = '{scl: scl, sda: sda_line};
    lai_alert_top i_dut (.clk_i, .rst_n_i, .clk_en_i, .dev_addr_i, .two_wire_sel_i, .alert_polarity_select_i,
        .alert_disable_i, .conv_valid_i, .conv_data_i, .limit_high_i, .limit_low_i, .stat1_rd_i, .stat2_rd_i,
        .bus_i, .stat1_o, .stat2_o, .alert_o, .alert_oe_n_o, .sda_o, .sda_oe_n_o, .answered_o);
    lai_smb_host i_host (.alert_line_i(line), .sda_i(sda_line), .scl_o(scl), .sda_low_o(host_low),
        .rx_o(rx), .n_ara_o(n_ara));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conv(input int src, input logic [9:0] v);
        @(posedge clk_i);
        conv_valid_i <= 7'h01 << src;
        conv_data_i[src*10+:10] <= v;
        @(posedge clk_i);
        conv_valid_i <= 7'h00;
        repeat (2) @(posedge clk_i);
        #1;
    endtask
    task automatic rd(input logic two);
        @(posedge clk_i);
        stat1_rd_i <= !two;
        stat2_rd_i <= two;
        @(posedge clk_i);
        stat1_rd_i <= 1'b0;
        stat2_rd_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
    endtask
    task automatic test_ara();
        int t;
        conv(0, 10'h300);
        chk("stat1", stat1_o, 8'h01);
        chk("line low", line, 1'b0);
        t = n_ara;
        for (int k = 0; k < 5000 && n_ara < t + 2; k++)
            @(posedge clk_i);
        chk("ara", rx, {dev_addr_i, 1'b1});
        rd(1'b0);
        chk("held", line, 1'b0);
        conv(0, 10'h100);
        chk("released", line, 1'b1);
        chk("stat1 clr", stat1_o, 8'h00);
        $display("test_ara done");
    endtask
    task automatic test_ain();
        rd(1'b1);
        conv(3, 10'h010);
        chk("stat2", stat2_o, 8'h01);
        conv(3, 10'h100);
        chk("latched", stat2_o, 8'h01);
        rd(1'b1);
        chk("stat2 clr", stat2_o, 8'h00);
        chk("line idle", line, 1'b1);
        clk_en_i <= 1'b0;
        conv(4, 10'h3ff);
        chk("frozen", stat2_o, 8'h00);
        clk_en_i <= 1'b1;
        $display("test_ain done");
    endtask
    task automatic test_push_pull();
        repeat (600) @(posedge clk_i);
        two_wire_sel_i <= 1'b0;
        alert_polarity_select_i <= 1'b1;
        conv(1, 10'h3ff);
        chk("stat1 ext", stat1_o, 8'h02);
        chk("act high", alert_o, 1'b1);
        alert_disable_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        chk("disabled", alert_oe_n_o | !alert_o, 1'b1);
        alert_disable_i <= 1'b0;
        alert_polarity_select_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
        chk("act low", alert_o, 1'b0);
        conv(1, 10'h100);
        rd(1'b0);
        chk("inactive", alert_o, 1'b1);
        $display("test_push_pull done");
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        forever #2 clk_i = ~clk_i;
    end
    initial
    begin
        #100000;
        n_fail++;
        print_verdict();
    end
    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        test_ara();
        test_ain();
        test_push_pull();
        print_verdict();
    end
endmodule
